// >>> src/isd_pkg.sv
// Purpose: shared constants for the inhibit / sync digital io block
// Assumes: single 250 MHz clock, synchronous active-low reset
// Notes: register map and mode encodings live here
// Contract
// - positive polarity: high pin level means active, low means inactive.
// - negative polarity: low pin level means active, high means inactive.
// - active inhibit clamps every affected output to lowest level at once.
// - inhibit mode off ignores the inhibit input completely; here the status bits and inhibit rise/fall interrupts still follow it.
// - latch mode: true edge disables output, stays disabled after input drops.
// - live mode: output disabled while inhibit true, enabled when false.
// - choosing sync function on sync pin sets companion pin function too.
// - slaves set to sync input before master is set to sync output.
// - coupled channels on a slave ignore local on/off, master switches them.
// - coupled channels across units switch together under master timing; here master coupled channels follow own local_on, slave ones the OR of them.
package isd_pkg;
  localparam int ISD_NCH = 4;
  localparam logic [3:0] ISD_ADDR_CTRL = 4'h0;
  localparam logic [3:0] ISD_ADDR_CHAN = 4'h4;
  localparam logic [3:0] ISD_ADDR_STAT = 4'h8;
  localparam logic [3:0] ISD_ADDR_INT_STAT = 4'hC;
  localparam logic [3:0] ISD_ADDR_INT_MASK = 4'hD;
  // ctrl field positions
  localparam int ISD_CTRL_INH_POL = 0;
  localparam int ISD_CTRL_SYNC_POL = 1;
  localparam int ISD_CTRL_MODE_LO = 2;
  localparam int ISD_CTRL_SYNC_LO = 4;
  localparam logic [7:0] ISD_CTRL_RST = 8'h00;
  localparam logic [7:0] ISD_CHAN_RST = 8'h00;
  localparam logic [2:0] ISD_INT_RST = 3'h0;
  // interrupt bits
  localparam int ISD_INT_INH_RISE = 0;
  localparam int ISD_INT_INH_FALL = 1;
  localparam int ISD_INT_SYNC_CHG = 2;
  typedef enum logic [1:0] {
    ISD_INH_OFF = 2'b00,
    ISD_INH_LATCH = 2'b01,
    ISD_INH_LIVE = 2'b11
  } isd_inh_mode_e;
  typedef enum logic [1:0] {
    ISD_SYNC_NONE = 2'b00,
    ISD_SYNC_SLAVE = 2'b01,
    ISD_SYNC_MASTER = 2'b11
  } isd_sync_role_e;
  localparam logic ISD_POL_POS = 1'b0;
endpackage : isd_pkg

// >>> src/isd_inhibit_sync_dio.sv
// Purpose: inhibit conditioning and master/slave output sync for channel enables
// Assumes: pins sampled on clock; register port with read data one cycle later
// Notes: output enables are active-low on the two-way sync pins
//
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module isd_inhibit_sync_dio #(
  parameter int NCH = isd_pkg::ISD_NCH
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic inhibit_pin,
  input wire logic sync_pin_in,
  output logic sync_pin_out,
  output logic sync_pin_oe_n,
  input wire logic sync_enable_pin_in,
  output logic sync_enable_pin_out,
  output logic sync_enable_pin_oe_n,
  input wire logic [NCH-1:0] local_on,
  output logic [NCH-1:0] chan_enable,
  output logic irq
);
  import isd_pkg::*;

  logic [7:0] ctrl_r;
  logic [7:0] chan_r;
  logic [2:0] int_stat_r;
  logic [2:0] int_mask_r;
  logic [1:0] inh_meta_r;
  logic [1:0] sync_meta_r;
  logic [1:0] sen_meta_r;
  logic inh_q_r;
  logic sync_q_r;
  logic inh_latched_r;
  logic [NCH-1:0] chan_enable_r;
  logic sync_out_r;
  logic sen_out_r;
  logic [7:0] reg_rdata_r;

  isd_inh_mode_e inh_mode;
  isd_sync_role_e sync_role;
  logic inh_active;
  logic sync_active;
  logic sen_active;
  logic inh_block;
  logic mode_wr;
  logic [NCH-1:0] couple_mask;
  logic [NCH-1:0] run_nxt;
  logic [2:0] int_event;

  function automatic logic isd_level(input logic pin, input logic pol);
    // positive polarity passes the pin, negative inverts it
    return (pol == ISD_POL_POS) ? pin : ~pin;
  endfunction : isd_level

  assign inh_mode = isd_inh_mode_e'(ctrl_r[ISD_CTRL_MODE_LO +: 2]);
  // the companion pin role follows the sync pin role, no own setting
  assign sync_role = isd_sync_role_e'(ctrl_r[ISD_CTRL_SYNC_LO +: 2]);
  assign couple_mask = chan_r[NCH-1:0];

  // register port
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ctrl_r <= ISD_CTRL_RST;
      chan_r <= ISD_CHAN_RST;
      int_mask_r <= ISD_INT_RST;
    end else if (reg_write) begin
      case (reg_addr)
        ISD_ADDR_CTRL: ctrl_r <= reg_wdata;
        ISD_ADDR_CHAN: chan_r <= reg_wdata;
        ISD_ADDR_INT_MASK: int_mask_r <= reg_wdata[2:0];
        default: ;
      endcase
    end
  end

  assign mode_wr = reg_write && (reg_addr == ISD_ADDR_CTRL) &&
                   (reg_wdata[ISD_CTRL_MODE_LO +: 2] != ctrl_r[ISD_CTRL_MODE_LO +: 2]);

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      reg_rdata_r <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        ISD_ADDR_CTRL: reg_rdata_r <= ctrl_r;
        ISD_ADDR_CHAN: reg_rdata_r <= chan_r;
        ISD_ADDR_STAT: reg_rdata_r <= {inh_latched_r, inh_active, sync_active, sen_active,
                                       chan_enable_r[3:0]};
        ISD_ADDR_INT_STAT: reg_rdata_r <= {5'h00, int_stat_r};
        ISD_ADDR_INT_MASK: reg_rdata_r <= {5'h00, int_mask_r};
        default: reg_rdata_r <= 8'h00;
      endcase
    end else begin
      reg_rdata_r <= 8'h00;
    end
  end
  assign reg_rdata = reg_rdata_r;

  // two-flop synchronisers; first stage read only by the second
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      inh_meta_r <= 2'b00;
      sync_meta_r <= 2'b00;
      sen_meta_r <= 2'b00;
    end else begin
      inh_meta_r <= {inh_meta_r[0], inhibit_pin};
      sync_meta_r <= {sync_meta_r[0], sync_pin_in};
      sen_meta_r <= {sen_meta_r[0], sync_enable_pin_in};
    end
  end

  assign inh_active = isd_level(inh_meta_r[1], ctrl_r[ISD_CTRL_INH_POL]);
  assign sync_active = isd_level(sync_meta_r[1], ctrl_r[ISD_CTRL_SYNC_POL]);
  assign sen_active = isd_level(sen_meta_r[1], ctrl_r[ISD_CTRL_SYNC_POL]);

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      inh_q_r <= 1'b0;
      sync_q_r <= 1'b0;
    end else begin
      inh_q_r <= inh_active;
      sync_q_r <= sync_active;
    end
  end

  // latch holds until mode changes; a mode write clears it even if a true edge arrives in the same cycle
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      inh_latched_r <= 1'b0;
    end else if (inh_mode == ISD_INH_LATCH && inh_active && !inh_q_r && !mode_wr) begin
      inh_latched_r <= 1'b1;
    end else if (mode_wr) begin
      inh_latched_r <= 1'b0;
    end
  end

  always_comb begin
    case (inh_mode)
      ISD_INH_OFF: inh_block = 1'b0;
      ISD_INH_LATCH: inh_block = inh_latched_r || (inh_active && !inh_q_r);
      ISD_INH_LIVE: inh_block = inh_active;
      default: inh_block = 1'b0;
    endcase
  end

  // slave coupled channels take run state from master lines only
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      if (sync_role == ISD_SYNC_SLAVE && couple_mask[i]) begin
        run_nxt[i] = sync_active && sen_active;
      end else begin
        run_nxt[i] = local_on[i];
      end
    end
    if (inh_block) begin
      run_nxt = '0;
    end
  end

  // master drives its coupled run state out, changes registered with channels
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      chan_enable_r <= '0;
      sync_out_r <= 1'b0;
      sen_out_r <= 1'b0;
    end else begin
      chan_enable_r <= run_nxt;
      sync_out_r <= (|(local_on & couple_mask)) && !inh_block;
      sen_out_r <= |couple_mask;
    end
  end
  assign chan_enable = chan_enable_r;

  // polarity applied on drive as well so both ends agree
  assign sync_pin_out = isd_level(sync_out_r, ctrl_r[ISD_CTRL_SYNC_POL]);
  assign sync_enable_pin_out = isd_level(sen_out_r, ctrl_r[ISD_CTRL_SYNC_POL]);
  // slave never drives, so pins stay safe while master configured later
  assign sync_pin_oe_n = (sync_role != ISD_SYNC_MASTER);
  assign sync_enable_pin_oe_n = (sync_role != ISD_SYNC_MASTER);

  // sticky interrupts, set wins over write-one clear
  assign int_event[ISD_INT_INH_RISE] = inh_active && !inh_q_r;
  assign int_event[ISD_INT_INH_FALL] = !inh_active && inh_q_r;
  assign int_event[ISD_INT_SYNC_CHG] = sync_active != sync_q_r;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      int_stat_r <= ISD_INT_RST;
    end else if (reg_write && reg_addr == ISD_ADDR_INT_STAT) begin
      int_stat_r <= (int_stat_r & ~reg_wdata[2:0]) | int_event;
    end else begin
      int_stat_r <= int_stat_r | int_event;
    end
  end
  assign irq = |(int_stat_r & int_mask_r);

endmodule : isd_inhibit_sync_dio

// >>> dv/isd_dio_sva.sv
// Purpose: port checks for isd_inhibit_sync_dio
// Assumes: ctrl, coupling and mask shadowed from register writes
// Notes: sync enable polarity unchecked, so slave check needs sync pol 0
`timescale 1ns/1ps
module isd_dio_sva #(
  parameter int NCH = 4
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic inhibit_pin,
  input wire logic sync_pin_in,
  input wire logic sync_pin_out,
  input wire logic sync_pin_oe_n,
  input wire logic sync_enable_pin_in,
  input wire logic sync_enable_pin_oe_n,
  input wire logic [NCH-1:0] local_on,
  input wire logic [NCH-1:0] chan_enable,
  input wire logic irq
);
  import isd_pkg::*;
  logic [5:0] c_r;
  logic [NCH-1:0] cpl_r;
  logic [2:0] mask_r;
  logic [1:0] cnt_r;
  logic latch_r;
  wire act = inhibit_pin ^ c_r[0];
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      c_r <= '0;
      cpl_r <= '0;
      mask_r <= '0;
    end else if (reg_write) begin
      if (reg_addr == ISD_ADDR_CTRL) c_r <= reg_wdata[5:0];
      if (reg_addr == ISD_ADDR_CHAN) cpl_r <= reg_wdata[NCH-1:0];
      if (reg_addr == ISD_ADDR_INT_MASK) mask_r <= reg_wdata[2:0];
    end
  end
  // level count: latch mode is only entered with inhibit idle
  always_ff @(posedge clock) begin
    if (!reset_n || c_r[3:2] != 2'h1 || !act) cnt_r <= '0;
    else if (cnt_r != 2'h3) cnt_r <= cnt_r + 2'h1;
  end
  always_ff @(posedge clock) begin
    if (!reset_n) latch_r <= 1'b0;
    else if (reg_write && reg_addr == ISD_ADDR_CTRL && reg_wdata[3:2] != c_r[3:2]) latch_r <= 1'b0;
    else if (cnt_r == 2'h3 && c_r[3:2] == 2'h1) latch_r <= 1'b1;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  chk_live_clamp: assert property ((c_r[3:2] == 2'h3 && act)[*4] |-> chan_enable == '0)
    else $error("live inhibit left a channel on");
  chk_off_follow: assert property ((!c_r[4] && !c_r[2] && $stable({local_on, c_r}))[*4] |->
    chan_enable == local_on) else $error("off mode enable differs from local");
  chk_latch_hold: assert property (latch_r |-> chan_enable == '0)
    else $error("latched inhibit released");
  chk_slave_ignore: assert property ((c_r[5:2] == 4'h4 && !c_r[1] &&
    $stable({sync_pin_in, sync_enable_pin_in, local_on, cpl_r}))[*4] |->
    (chan_enable & cpl_r) == ((sync_pin_in && sync_enable_pin_in) ? cpl_r : '0))
    else $error("coupled slave channel not from sync lines");
  chk_oe_release: assert property ((c_r[5:4] != 2'h3)[*2] |-> sync_pin_oe_n && sync_enable_pin_oe_n)
    else $error("pins driven outside master role");
  chk_oe_master: assert property ((c_r[5:4] == 2'h3)[*3] |-> !sync_pin_oe_n && !sync_enable_pin_oe_n)
    else $error("master pair not driven");
  chk_master_sync: assert property ((c_r[5:2] == 4'hC && $stable({local_on, cpl_r}))[*4] |->
    sync_pin_out == ((|(local_on & cpl_r)) ^ c_r[1])) else $error("master sync level wrong");
  chk_irq_masked: assert property ((mask_r == 3'h0)[*2] |-> !irq)
    else $error("irq with all masked");
  cover property (latch_r);
  cover property (!sync_pin_oe_n);
  cover property (irq);
endmodule : isd_dio_sva
bind isd_inhibit_sync_dio isd_dio_sva #(.NCH(NCH)) i_isd_dio_sva (.*);

// >>> dv/isd_ext_ctrl.sv
// Purpose: external controller or peer mainframe on the io pins
// Assumes: levels set by the bench
// Notes: a line the block drives reads back the block's value
`timescale 1ns/1ps
module isd_ext_ctrl (
  input wire logic inh_lvl,
  input wire logic sync_lvl,
  input wire logic sen_lvl,
  input wire logic sync_pin_out,
  input wire logic sync_pin_oe_n,
  input wire logic sync_enable_pin_out,
  input wire logic sync_enable_pin_oe_n,
  output logic inhibit_pin,
  output logic sync_pin_in,
  output logic sync_enable_pin_in
);
  assign inhibit_pin = inh_lvl;
  // peer master drives only while the block has released the pair
  assign sync_pin_in = sync_pin_oe_n ? sync_lvl : sync_pin_out;
  assign sync_enable_pin_in = sync_enable_pin_oe_n ? sen_lvl : sync_enable_pin_out;
endmodule : isd_ext_ctrl

// >>> dv/isd_inhibit_sync_dio_test.sv
// Purpose: self-checking bench for isd_inhibit_sync_dio
// Assumes: 250 MHz clock, reset held 16 cycles
// Notes: pin to enable takes three edges, four are waited
`timescale 1ns/1ps
module isd_inhibit_sync_dio_test;
  import isd_pkg::*;
  typedef struct packed {logic [7:0] ctrl; logic [3:0] cpl; logic [3:0] pins; logic [3:0] lon; logic [3:0] exp;} isd_row_s;
  isd_row_s rows [8] = '{24'h0004AA, 24'h0C04F0, 24'h0C0055, 24'h0D00F0, 24'h0D0466, 24'h103303, 24'h1031FC, 24'h1037FF};
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic inh_lvl = 1'b0, sync_lvl = 1'b0, sen_lvl = 1'b0;
  logic [3:0] local_on = 4'h0;
  logic [7:0] reg_rdata;
  logic [3:0] chan_enable;
  logic inhibit_pin, sync_pin_in, sync_pin_out, sync_pin_oe_n, irq;
  logic sync_enable_pin_in, sync_enable_pin_out, sync_enable_pin_oe_n;
  int miscompares = 0;
  int cmp_count = 0;
  isd_inhibit_sync_dio i_isd_inhibit_sync_dio (.*);
  isd_ext_ctrl i_isd_ext_ctrl (.*);
  always #2 clock = ~clock;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask : rd
  task automatic apply(input logic [2:0] p, input logic [3:0] l);
    @(posedge clock);
    {inh_lvl, sync_lvl, sen_lvl} <= p;
    local_on <= l;
    repeat (4) @(posedge clock);
    #1;
  endtask : apply
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test
  initial begin
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    rd(ISD_ADDR_CTRL, ISD_CTRL_RST);
    rd(ISD_ADDR_CHAN, ISD_CHAN_RST);
    rd(ISD_ADDR_INT_MASK, 8'h00);
    rd(4'h3, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr(ISD_ADDR_CTRL, rows[i].ctrl);
      wr(ISD_ADDR_CHAN, {4'h0, rows[i].cpl});
      apply(rows[i].pins[2:0], rows[i].lon);
      check({4'h0, chan_enable}, {4'h0, rows[i].exp});
    end
    apply(3'h0, 4'hF);
    wr(ISD_ADDR_CTRL, 8'h04);
    wr(ISD_ADDR_CHAN, 8'h00);
    apply(3'h0, 4'hF);
    check({4'h0, chan_enable}, 8'h0F);
    apply(3'h4, 4'hF);
    apply(3'h0, 4'hF);
    check({4'h0, chan_enable}, 8'h00);
    rd(ISD_ADDR_STAT, 8'h80);
    wr(ISD_ADDR_CTRL, 8'h04);
    apply(3'h0, 4'hF);
    check({4'h0, chan_enable}, 8'h00);
    wr(ISD_ADDR_CTRL, 8'h00);
    apply(3'h0, 4'hF);
    check({4'h0, chan_enable}, 8'h0F);
    wr(ISD_ADDR_CHAN, 8'h01);
    wr(ISD_ADDR_CTRL, 8'h30);
    apply(3'h0, 4'h1);
    check({4'h0, sync_enable_pin_out, sync_pin_out, sync_pin_oe_n, sync_enable_pin_oe_n}, 8'h0C);
    apply(3'h0, 4'h2);
    check({4'h0, sync_enable_pin_out, sync_pin_out, sync_pin_oe_n, sync_enable_pin_oe_n}, 8'h08);
    wr(ISD_ADDR_CTRL, 8'h0C);
    wr(ISD_ADDR_INT_STAT, 8'h07);
    wr(ISD_ADDR_INT_MASK, 8'h01);
    apply(3'h4, 4'h0);
    check({7'h00, irq}, 8'h01);
    rd(ISD_ADDR_INT_STAT, 8'h01);
    wr(ISD_ADDR_INT_MASK, 8'h00);
    apply(3'h4, 4'h0);
    check({7'h00, irq}, 8'h00);
    wr(ISD_ADDR_INT_MASK, 8'h01);
    apply(3'h4, 4'h0);
    check({7'h00, irq}, 8'h01);
    wr(ISD_ADDR_INT_STAT, 8'h01);
    apply(3'h4, 4'h0);
    check({7'h00, irq}, 8'h00);
    stop_test();
  end
endmodule : isd_inhibit_sync_dio_test
